// ==== verilog/flash_read_pkg.sv ====
// Shared constants and types for the flash read strobe timing block
package flash_read_pkg;

    // Widths of the core, flash and register bus sides
    localparam int CODE_ADDR_W = 16;
    localparam int WORD_ADDR_W = 14;
    localparam int BUS_ADDR_W = 8;

    // Register byte addresses on the register bus
    localparam logic [7:0] CACHE_CONTROL_OFFSET = 8'h84;
    localparam logic [7:0] FLASH_TIMING_OFFSET = 8'h88;
    localparam logic [7:0] READ_STATUS_OFFSET = 8'h8C;

    // Field positions inside cache_control_reg
    localparam int PF_ENABLE_BIT = 5;
    localparam int FLUSH_BIT = 4;

    // Field positions inside flash_timing_control_reg
    localparam int WIDTH_FIELD_LSB = 4;
    localparam int WIDTH_FIELD_MSB = 5;

    // Field positions inside the status register
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_LINE_VALID_BIT = 1;

    // Reset values; the width field reset gives the one-cycle strobe
    localparam logic PF_ENABLE_RESET = 1'b1;
    localparam logic [1:0] WIDTH_FIELD_RESET = 2'h0;
    localparam logic [1:0] WIDTH_ONE_CYCLE = 2'h0;

    // System clock limit that the reset timing is good for
    localparam int SLOW_CLOCK_LIMIT_MHZ = 25;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Read sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STROBE = 2'b01,
        ST_DONE = 2'b10
    } rd_state_t;

endpackage : flash_read_pkg

// ==== verilog/read_strobe_gen.sv ====
// Flash read strobe generator, one or two cycles wide
`timescale 1ns/1ps
module read_strobe_gen
    import flash_read_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic start,
    input wire logic two_cycle,
    // Strobe
    output logic strobe,
    output logic last
);

    logic strobe_reg;
    logic extra_reg;

    // Width is latched at start, so a field change mid-read cannot stretch a strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_reg <= 1'b0;
            extra_reg <= 1'b0;
        end else if (start) begin
            strobe_reg <= 1'b1;
            extra_reg <= two_cycle;
        end else if (strobe_reg && extra_reg) begin
            extra_reg <= 1'b0;
        end else begin
            strobe_reg <= 1'b0;
        end
    end

    assign strobe = strobe_reg;
    assign last = strobe_reg && !extra_reg;

    a_strobe_one_wide: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (start && !two_cycle) |=> strobe ##1 !strobe)
        else $error("one-cycle strobe has wrong width");

    a_strobe_two_wide: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (start && two_cycle) |=> strobe [*2] ##1 !strobe)
        else $error("two-cycle strobe has wrong width");

endmodule : read_strobe_gen

// ==== verilog/prefetch_line.sv ====
// Linear prefetch line: one tag and one four-byte slot
`timescale 1ns/1ps
module prefetch_line
    import flash_read_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Fill and flush
    input wire logic load,
    input wire logic [WORD_ADDR_W-1:0] load_tag,
    input wire logic [31:0] load_word,
    input wire logic flush,
    // Lookup
    input wire logic [WORD_ADDR_W-1:0] look_tag,
    input wire logic [1:0] look_sel,
    output logic hit,
    output logic [7:0] look_byte,
    output logic valid
);

    logic valid_reg;
    logic [WORD_ADDR_W-1:0] tag_reg;
    logic [31:0] slot_reg;

    // A fill in the flush cycle wins, so freshly fetched code is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            valid_reg <= 1'b0;
        end else if (load) begin
            valid_reg <= 1'b1;
        end else if (flush) begin
            valid_reg <= 1'b0;
        end
    end

    // Tag and four-byte slot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tag_reg <= '0;
            slot_reg <= 32'h0;
        end else if (load) begin
            tag_reg <= load_tag;
            slot_reg <= load_word;
        end
    end

    assign hit = valid_reg && (tag_reg == look_tag);
    assign look_byte = slot_reg[{look_sel, 3'b000} +: 8];
    assign valid = valid_reg;

    a_line_fill_kept: assert property (
        @(posedge aclk) disable iff (!aresetn)
        load |=> valid_reg && (tag_reg == $past(load_tag)) && (slot_reg == $past(load_word)))
        else $error("prefetch line did not keep the fetched word");

endmodule : prefetch_line

// ==== verilog/flash_read_ctrl.sv ====
// Flash read strobe timing controller with register slave and prefetch line
// Function
// - Reset timing suits clocks up to 25 MHz
// - Every data read or fetch issues strobe; a fetch that hits the prefetch line issues none
// - Strobe one or two cycles by field
// - Flash active only while strobe high
// - Prefetch fetches four bytes per access
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module flash_read_ctrl
    import flash_read_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [BUS_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [BUS_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Core read requests, held until rd_ack
    input wire logic code_req,
    input wire logic [CODE_ADDR_W-1:0] code_addr,
    input wire logic data_req,
    input wire logic [CODE_ADDR_W-1:0] data_addr,
    output logic rd_ack,
    output logic [7:0] rd_byte,
    // Flash array
    output logic [WORD_ADDR_W-1:0] flash_addr,
    output logic flash_strobe,
    output logic flash_lowpower,
    input wire logic [31:0] flash_rdata
);

    // Register state
    logic prefetch_engine_enable_reg;
    logic [1:0] read_strobe_width_field_reg;

    // Write channel holding state
    logic aw_held_reg;
    logic [BUS_ADDR_W-1:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic w_lane0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    // Read channel state
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Read sequencer state
    rd_state_t state_reg;
    rd_state_t state_next;
    logic src_code_reg;
    logic [CODE_ADDR_W-1:0] addr_reg;
    logic [7:0] byte_reg;

    // Internal nets
    logic do_write;
    logic wr_mapped;
    logic flush_pulse;
    logic [31:0] rd_mux;
    logic rd_mapped;
    logic strobe_start;
    logic strobe_last;
    logic line_hit;
    logic line_valid;
    logic line_load;
    logic [7:0] line_byte;
    logic code_from_line;

    // Write address and data are taken in either order and held until used
    assign awready = !aw_held_reg && !bvalid_reg;
    assign wready = !w_held_reg && !bvalid_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_mapped = ({aw_addr_reg[7:2], 2'b00} == CACHE_CONTROL_OFFSET) ||
                       ({aw_addr_reg[7:2], 2'b00} == FLASH_TIMING_OFFSET) ||
                       ({aw_addr_reg[7:2], 2'b00} == READ_STATUS_OFFSET);

    // Write address holder
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (awvalid && awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    // Write data holder
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_lane0_reg <= 1'b0;
        end else if (wvalid && wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= wdata;
            w_lane0_reg <= wstrb[0];
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    // Control registers; only byte lane 0 carries them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prefetch_engine_enable_reg <= PF_ENABLE_RESET;
            read_strobe_width_field_reg <= WIDTH_FIELD_RESET;
        end else if (do_write && w_lane0_reg) begin
            if ({aw_addr_reg[7:2], 2'b00} == CACHE_CONTROL_OFFSET) begin
                prefetch_engine_enable_reg <= w_data_reg[PF_ENABLE_BIT];
            end
            if ({aw_addr_reg[7:2], 2'b00} == FLASH_TIMING_OFFSET) begin
                read_strobe_width_field_reg <= w_data_reg[WIDTH_FIELD_MSB:WIDTH_FIELD_LSB];
            end
        end
    end

    // Flush is write-one, it reads back as zero
    assign flush_pulse = do_write && w_lane0_reg && w_data_reg[FLUSH_BIT] &&
                         ({aw_addr_reg[7:2], 2'b00} == CACHE_CONTROL_OFFSET);

    // Read data mux
    always_comb begin
        rd_mux = 32'h0;
        rd_mapped = 1'b1;
        unique case ({araddr[7:2], 2'b00})
            CACHE_CONTROL_OFFSET: begin
                rd_mux[PF_ENABLE_BIT] = prefetch_engine_enable_reg;
            end
            FLASH_TIMING_OFFSET: begin
                rd_mux[WIDTH_FIELD_MSB:WIDTH_FIELD_LSB] = read_strobe_width_field_reg;
            end
            READ_STATUS_OFFSET: begin
                rd_mux[STATUS_BUSY_BIT] = (state_reg != ST_IDLE);
                rd_mux[STATUS_LINE_VALID_BIT] = line_valid;
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    // Read channel: one outstanding read, answered the cycle after the address
    assign arready = !rvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // Data reads take priority; a fetch that hits the line needs no strobe
    assign code_from_line = prefetch_engine_enable_reg && line_hit;
    assign strobe_start = (state_reg == ST_IDLE) &&
                          (data_req || (code_req && !code_from_line));

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (data_req || code_req) begin
                    state_next = strobe_start ? ST_STROBE : ST_DONE;
                end
            end
            ST_STROBE: begin
                if (strobe_last) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Latch the request source and address as the strobe starts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_code_reg <= 1'b0;
            addr_reg <= '0;
        end else if (strobe_start) begin
            src_code_reg <= !data_req;
            addr_reg <= data_req ? data_addr : code_addr;
        end
    end

    // Byte returned to the core, from the line or from the flash word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_reg <= 8'h00;
        end else if (state_reg == ST_IDLE && !data_req && code_req && code_from_line) begin
            byte_reg <= line_byte;
        end else if (state_reg == ST_STROBE && strobe_last) begin
            byte_reg <= flash_rdata[{addr_reg[1:0], 3'b000} +: 8];
        end
    end

    assign rd_ack = (state_reg == ST_DONE);
    assign rd_byte = byte_reg;
    assign flash_addr = addr_reg[CODE_ADDR_W-1:2];

    // The whole four-byte word of a code miss fills the line
    assign line_load = (state_reg == ST_STROBE) && strobe_last &&
                       src_code_reg && prefetch_engine_enable_reg;

    // The array is powered only while the strobe is high
    assign flash_lowpower = !flash_strobe;

    read_strobe_gen u_strobe (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(strobe_start),
        .two_cycle(read_strobe_width_field_reg != WIDTH_ONE_CYCLE),
        .strobe(flash_strobe),
        .last(strobe_last)
    );

    prefetch_line u_line (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(line_load),
        .load_tag(addr_reg[CODE_ADDR_W-1:2]),
        .load_word(flash_rdata),
        .flush(flush_pulse),
        .look_tag(code_addr[CODE_ADDR_W-1:2]),
        .look_sel(code_addr[1:0]),
        .hit(line_hit),
        .look_byte(line_byte),
        .valid(line_valid)
    );

    a_reset_slow_timing: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> (read_strobe_width_field_reg == WIDTH_FIELD_RESET))
        else $error("width field not at slow-clock default after reset");

    a_data_read_strobe: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_IDLE && data_req) |=> flash_strobe ##[1:2] rd_ack)
        else $error("data read did not strobe the flash");

    a_flash_idle_low: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (state_reg != ST_STROBE) |-> (!flash_strobe && flash_lowpower))
        else $error("flash active outside a read strobe");

    a_line_hit_quiet: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == ST_IDLE && !data_req && code_req && code_from_line)
        |=> !flash_strobe && rd_ack && (rd_byte == $past(line_byte)))
        else $error("fetch hitting the line touched the flash");

endmodule : flash_read_ctrl

// ==== verification/flash_array_model.sv ====
// Behavioural model of the program flash array behind the read strobe
`timescale 1ns/1ps
module flash_array_model
    import flash_read_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Read port
    input wire logic [WORD_ADDR_W-1:0] flash_addr,
    input wire logic flash_strobe,
    output logic [31:0] flash_rdata
);
    logic [31:0] last_reg;

    // Stored contents follow a fixed pattern of the word address
    function automatic logic [31:0] contents(input logic [WORD_ADDR_W-1:0] w);
        return {w[7:0] ^ 8'hA5, w[7:0] ^ 8'h5A, w[13:6], w[7:0]};
    endfunction : contents

    // Remember the last value so that an idle array never repeats it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_reg <= 32'h0;
        end else begin
            last_reg <= flash_rdata;
        end
    end

    // Whole word only while strobed; in low power the output flips every cycle
    assign flash_rdata = flash_strobe ? contents(flash_addr) : ~last_reg;
endmodule : flash_array_model

// ==== verification/flash_read_ctrl_tb_top.sv ====
// Self-checking bench for the flash read strobe timing controller
`timescale 1ns/1ps
module flash_read_ctrl_tb_top
    import flash_read_pkg::*;
();
    typedef struct packed {
        logic [1:0] wf;
        logic pf;
        logic dat;
        logic [15:0] addr;
        logic [3:0] lat;
        logic [3:0] ns;
    } row_t;
    // Width field, prefetch, data or code, address, latency, strobes
    row_t rows [7] = '{
        '{2'h0, 1'h1, 1'h1, 16'h0013, 4'h3, 4'h1},
        '{2'h1, 1'h1, 1'h1, 16'h0102, 4'h4, 4'h1},
        '{2'h2, 1'h1, 1'h0, 16'h0208, 4'h4, 4'h1},
        '{2'h2, 1'h1, 1'h0, 16'h020B, 4'h2, 4'h0},
        '{2'h3, 1'h1, 1'h0, 16'h0300, 4'h4, 4'h1},
        '{2'h0, 1'h0, 1'h0, 16'h0301, 4'h3, 4'h1},
        '{2'h0, 1'h0, 1'h0, 16'h0302, 4'h3, 4'h1}
    };
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h0;
    logic [7:0] araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic code_req = 1'h0, data_req = 1'h0;
    logic [15:0] code_addr = 16'h0, data_addr = 16'h0;
    logic awready, wready, bvalid, arready, rvalid, rd_ack, flash_strobe, flash_lowpower;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, flash_rdata;
    logic [7:0] rd_byte;
    logic [13:0] flash_addr, strobe_addr;
    logic [1:0] prev_wf;
    logic prev_pf;
    int n_fail = 0, checks_done = 0, hi_run = 0, n_strobes = 0, last_width = 0;

    flash_read_ctrl flash_read_ctrl_i (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .code_req(code_req), .code_addr(code_addr),
        .data_req(data_req), .data_addr(data_addr), .rd_ack(rd_ack),
        .rd_byte(rd_byte), .flash_addr(flash_addr), .flash_strobe(flash_strobe),
        .flash_lowpower(flash_lowpower), .flash_rdata(flash_rdata));
    flash_array_model flash_array_model_i (.aclk(aclk), .aresetn(aresetn),
        .flash_addr(flash_addr), .flash_strobe(flash_strobe), .flash_rdata(flash_rdata));

    // 250 MHz clock
    always #2 aclk = ~aclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Expected flash word, worked out apart from the model
    function automatic logic [31:0] word_of(input logic [13:0] w);
        return {w[7:0] ^ 8'hA5, w[7:0] ^ 8'h5A, w[13:6], w[7:0]};
    endfunction : word_of

    // Strobe monitor: width, count and address of each flash read
    always @(posedge aclk) begin
        if (aresetn) chk({31'h0, flash_lowpower}, {31'h0, !flash_strobe});
        if (flash_strobe) begin
            hi_run++;
            strobe_addr = flash_addr;
        end else if (hi_run != 0) begin
            last_width = hi_run;
            n_strobes++;
            hi_run = 0;
        end
    end

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'h1) begin
                aw_done = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w_done && wready === 1'h1) begin
                w_done = 1'h1;
                wvalid <= 1'h0;
            end
        end
        bready <= 1'h1;
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        // Ready raised only once the address is taken, so back-to-back reads never
        // lower and raise it in one time step
        arvalid <= 1'h0;
        rready <= 1'h1;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd

    // Width change the safe way: prefetch off, new width, prefetch back
    task automatic set_timing(input logic [1:0] wf, input logic pf);
        wr(CACHE_CONTROL_OFFSET, 32'h0, 4'hF, RESP_OKAY);
        wr(FLASH_TIMING_OFFSET, {26'h0, wf, 4'h0}, 4'hF, RESP_OKAY);
        wr(CACHE_CONTROL_OFFSET, 32'(pf) << PF_ENABLE_BIT, 4'hF, RESP_OKAY);
        rd(FLASH_TIMING_OFFSET, {26'h0, wf, 4'h0}, RESP_OKAY);
    endtask : set_timing

    // Core read held until acknowledged; latency counted from the request
    task automatic crd(input logic dat, input logic [15:0] a, input logic [1:0] wf,
                       input int lat, input int ns);
        int n;
        int s0;
        logic [31:0] w;
        n = 0;
        s0 = n_strobes;
        w = word_of(a[15:2]);
        data_addr <= a;
        code_addr <= a;
        data_req <= dat;
        code_req <= !dat;
        do begin
            @(posedge aclk);
            n++;
        end while (rd_ack !== 1'h1);
        data_req <= 1'h0;
        code_req <= 1'h0;
        chk({24'h0, rd_byte}, {24'h0, w[8*a[1:0] +: 8]});
        chk(n, lat);
        // The monitor counted the strobe at the edge the ack was seen
        @(posedge aclk);
        chk(n_strobes - s0, ns);
        if (ns != 0) begin
            chk(last_width, (wf == WIDTH_ONE_CYCLE) ? 1 : 2);
            chk({18'h0, strobe_addr}, {18'h0, a[15:2]});
        end
    endtask : crd

    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(CACHE_CONTROL_OFFSET, 32'h20, RESP_OKAY);
        rd(FLASH_TIMING_OFFSET, 32'h0, RESP_OKAY);
        rd(READ_STATUS_OFFSET, 32'h0, RESP_OKAY);
        rd(8'h90, 32'h0, RESP_SLVERR);
        wr(8'h90, 32'hFF, 4'hF, RESP_SLVERR);
        $display("test reset values done");
        prev_wf = WIDTH_FIELD_RESET;
        prev_pf = PF_ENABLE_RESET;
        foreach (rows[i]) begin
            if (rows[i].wf !== prev_wf || rows[i].pf !== prev_pf) begin
                set_timing(rows[i].wf, rows[i].pf);
            end
            prev_wf = rows[i].wf;
            prev_pf = rows[i].pf;
            crd(rows[i].dat, rows[i].addr, rows[i].wf, rows[i].lat, rows[i].ns);
            $display("test row %0d done", i);
        end
        // Flush empties the line, so the next fetch goes back to the array
        set_timing(2'h0, 1'h1);
        crd(1'h0, 16'h0400, 2'h0, 3, 1);
        rd(READ_STATUS_OFFSET, 32'h2, RESP_OKAY);
        wr(CACHE_CONTROL_OFFSET, 32'h30, 4'hF, RESP_OKAY);
        rd(READ_STATUS_OFFSET, 32'h0, RESP_OKAY);
        crd(1'h0, 16'h0401, 2'h0, 3, 1);
        crd(1'h0, 16'h0402, 2'h0, 2, 0);
        $display("test flush done");
        // Masked and read-only writes change nothing
        wr(FLASH_TIMING_OFFSET, 32'h30, 4'h0, RESP_OKAY);
        rd(FLASH_TIMING_OFFSET, 32'h0, RESP_OKAY);
        wr(READ_STATUS_OFFSET, 32'hFF, 4'hF, RESP_OKAY);
        rd(READ_STATUS_OFFSET, 32'h2, RESP_OKAY);
        $display("test ignored writes done");
        // Reset in mid-run brings back the slow-clock timing
        wr(FLASH_TIMING_OFFSET, 32'h10, 4'hF, RESP_OKAY);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(FLASH_TIMING_OFFSET, 32'h0, RESP_OKAY);
        crd(1'h1, 16'h0123, 2'h0, 3, 1);
        $display("test second reset done");
        tally_and_finish();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
endmodule : flash_read_ctrl_tb_top
